//--- pkg/ssppe_pkg.sv
// Purpose: constants for the serial port engine (spi mode)
// Assumes: 8-bit register port, 25 MHz system clock
// Notes: register offsets are the printed addresses

package ssppe_pkg;
  localparam logic [7:0] ADDR_PIR = 8'h0c;
  localparam logic [7:0] ADDR_BUF = 8'h13;
  localparam logic [7:0] ADDR_CON = 8'h14;
  localparam logic [7:0] ADDR_PIE = 8'h8c;
  localparam logic [7:0] ADDR_STAT = 8'h94;
  localparam logic [7:0] ADDR_PORTA_DIR = 8'h85;
  localparam logic [7:0] ADDR_PORTC_DIR = 8'h87;
  localparam logic [7:0] RESET_CON = 8'h00;
  localparam logic [7:0] RESET_STAT = 8'h00;
  localparam logic [7:0] RESET_PIR = 8'h00;
  localparam logic [7:0] RESET_PIE = 8'h00;
  localparam logic [5:0] RESET_DIR = 6'h3f;
  localparam int CON_COLLISION = 7;
  localparam int CON_OVERFLOW = 6;
  localparam int CON_ENABLE = 5;
  localparam int CON_POLARITY = 4;
  localparam int STAT_SAMPLE = 7;
  localparam int STAT_EDGE = 6;
  localparam int STAT_FULL = 0;
  localparam int PIR_SERIAL = 3;
  localparam int DIR_SDI = 4;
  localparam int DIR_SDO = 5;
  localparam int DIR_SCK = 3;
  localparam int DIR_SS = 5;
  localparam logic [3:0] MODE_DIV4 = 4'h0;
  localparam logic [3:0] MODE_DIV16 = 4'h1;
  localparam logic [3:0] MODE_DIV64 = 4'h2;
  localparam logic [3:0] MODE_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
  localparam logic [3:0] MODE_SLAVE = 4'h5;
  // half-bit periods minus one, in system cycles, for the master rates
  localparam logic [5:0] HALF_DIV4 = 6'h01;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV64 = 6'h1f;
  localparam int BIT_COUNT = 8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LEAD = 3'b010,
    ST_TRAIL = 3'b100
  } ssppe_state_type;
endpackage

//--- hw/ssppe_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single system clock
// Notes: first flop is read only by the second

`timescale 1ns/100ps
`default_nettype none
module ssppe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  input wire logic [WIDTH-1:0] resetValue,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stageOne <= resetValue;
      syncOut <= resetValue;
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end
endmodule
`default_nettype wire

//--- hw/ssppe_engine.sv
// Purpose: spi engine of the synchronous serial port, register port and pins
// Assumes: 25 MHz clk_sys; pins pass two flops; external sck slow vs clk_sys
// Notes: direction registers included so serial roles can be overridden
//
// Our own choice: the strobed register port.

`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - shift register hidden; only buffer reads/writes reach it
// - port runs only while enable bit is set; clear, reconfigure, set
// - pin roles follow direction bits: sdi in, sdo out, sck per mode, ss in
// - direction opposite to serial role frees the pin as general i/o
// - shift out on programmed edge, capture on the opposite edge; edge bit only stored, shift on return to idle
// - master starts a byte right after a buffer write
// - master with sck as input keeps sampling sdi at the set rate
// - slave shifts on external clocks, flags interrupt at last bit
// - polarity bit sets sck idle level; msb first
// - master rate is fosc/4, /16, /64 or timer output/2
// - slave keeps working in sleep, byte completion can wake device
// - slave-select gating only in mode 04h with ss direction input
// - gated and ss low drives sdo; ss high floats sdo at once
// - gated mode resets the engine while ss is high
// - sdo as input stops transmission; sdi may stay input
// - eight bits move to buffer, set full and interrupt flags; read clears full
// - buffer write during transfer is dropped and sets collision flag
// - overflow only in slave mode when buffer still unread; byte lost
// - modes 0-3 master rates, 4 slave gated, 5 slave with free ss
module ssppe_engine
  import ssppe_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic timerTwoOutput,
  input wire logic sleepMode,
  output logic wakeRequest,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sdiIn,
  output logic sdoOut,
  output logic sdoOe,
  input wire logic ssIn
);
  logic [7:0] serialControl;
  logic [1:0] statusCfg;
  logic bufferFull;
  logic [7:0] pirFlags;
  logic [7:0] pieBits;
  logic [5:0] portcDirection;
  logic [5:0] portaDirection;
  logic [7:0] serialBuffer;
  logic [7:0] shiftRegister;
  logic [3:0] bitCount;
  logic [5:0] divCount;
  logic timerSeen;
  logic timerHalf;
  logic sckSync;
  logic ssSync;
  logic sdiSync;
  logic sckPrev;
  logic sampledBit;
  ssppe_state_type state;

  logic portOn;
  logic masterMode;
  logic slaveMode;
  logic gateActive;
  logic slaveHold;
  logic byteDone;
  logic leadEvent;
  logic trailEvent;
  logic rateTick;
  logic busy;
  logic bufWrite;
  logic bufRead;
  logic sckEdgeRise;
  logic sckEdgeFall;
  logic [5:0] halfPeriod;

  function automatic logic isHit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  assign portOn = serialControl[CON_ENABLE];
  assign masterMode = portOn && serialControl[3:0] <= MODE_TIMER;
  assign slaveMode = portOn && (serialControl[3:0] == MODE_SLAVE_SS || serialControl[3:0] == MODE_SLAVE);
  assign gateActive = slaveMode && serialControl[3:0] == MODE_SLAVE_SS && portaDirection[DIR_SS];
  assign slaveHold = gateActive && ssSync;
  assign bufWrite = regWrite && isHit(regAddr, ADDR_BUF);
  assign bufRead = regRead && isHit(regAddr, ADDR_BUF);
  assign busy = state != ST_IDLE;

  ssppe_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .asyncIn({sckIn, ssIn, sdiIn, timerTwoOutput}),
    .resetValue(4'h0),
    .syncOut({sckSync, ssSync, sdiSync, timerSeen})
  );

  // divider: produces a half-bit tick for master rates
  always_comb begin
    unique case (serialControl[1:0])
      2'b00: halfPeriod = HALF_DIV4;
      2'b01: halfPeriod = HALF_DIV16;
      default: halfPeriod = HALF_DIV64;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !busy) begin
      divCount <= 6'h00;
    end else if (divCount == halfPeriod) begin
      divCount <= 6'h00;
    end else begin
      divCount <= divCount + 6'h01;
    end
  end

  // timer output edges halved: each timer pulse is one half bit
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timerHalf <= 1'b0;
    end else begin
      timerHalf <= timerSeen;
    end
  end

  always_comb begin
    if (serialControl[3:0] == MODE_TIMER) begin
      rateTick = timerSeen && !timerHalf;
    end else begin
      rateTick = divCount == halfPeriod;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sckPrev <= 1'b0;
    end else begin
      sckPrev <= sckSync;
    end
  end
  assign sckEdgeRise = sckSync && !sckPrev;
  assign sckEdgeFall = !sckSync && sckPrev;

  always_comb begin
    if (masterMode) begin
      leadEvent = rateTick && state == ST_LEAD;
      trailEvent = rateTick && state == ST_TRAIL;
    end else if (slaveMode && !slaveHold) begin
      // leaving idle level samples, return to idle shifts (edge bit clear)
      leadEvent = serialControl[CON_POLARITY] ? sckEdgeFall : sckEdgeRise;
      trailEvent = serialControl[CON_POLARITY] ? sckEdgeRise : sckEdgeFall;
    end else begin
      leadEvent = 1'b0;
      trailEvent = 1'b0;
    end
  end

  assign byteDone = trailEvent && bitCount == 4'(BIT_COUNT - 1) && state == ST_TRAIL;

  // shift engine: sample on lead, shift out on trail, msb first
  always_ff @(posedge clk_sys) begin
    if (reset || !portOn || slaveHold) begin
      state <= ST_IDLE;
      bitCount <= 4'h0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (masterMode && bufWrite) begin
            state <= ST_LEAD;
          end else if (slaveMode && leadEvent) begin
            state <= ST_TRAIL;
          end
        end
        ST_LEAD: begin
          if (leadEvent) begin
            state <= ST_TRAIL;
          end
        end
        ST_TRAIL: begin
          if (trailEvent) begin
            bitCount <= byteDone ? 4'h0 : bitCount + 4'h1;
            state <= byteDone ? ST_IDLE : (masterMode ? ST_LEAD : ST_TRAIL);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shiftRegister <= 8'h00;
    end else if (bufWrite && !busy) begin
      shiftRegister <= regWriteData;
    end else if (trailEvent && state == ST_TRAIL) begin
      shiftRegister <= {shiftRegister[6:0], sampledBit};
    end
  end

  // sample kept apart so the unsent lsb is not overwritten before it leaves
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sdoOut <= 1'b0;
      sampledBit <= 1'b0;
    end else begin
      sdoOut <= shiftRegister[7];
      if (leadEvent) begin
        sampledBit <= sdiSync;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serialBuffer <= 8'h00;
    end else if (byteDone && !(slaveMode && bufferFull)) begin
      serialBuffer <= {shiftRegister[6:0], sampledBit};
    end
  end

  // flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bufferFull <= 1'b0;
    end else if (byteDone) begin
      bufferFull <= 1'b1;
    end else if (bufRead || !portOn) begin
      bufferFull <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serialControl <= RESET_CON;
    end else begin
      if (regWrite && isHit(regAddr, ADDR_CON)) begin
        serialControl <= regWriteData;
      end
      if (bufWrite && busy) begin
        serialControl[CON_COLLISION] <= 1'b1;
      end
      if (byteDone && slaveMode && bufferFull) begin
        serialControl[CON_OVERFLOW] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      statusCfg <= RESET_STAT[7:6];
      pirFlags <= RESET_PIR;
      pieBits <= RESET_PIE;
      portcDirection <= RESET_DIR;
      portaDirection <= RESET_DIR;
    end else begin
      if (regWrite && isHit(regAddr, ADDR_STAT)) begin
        statusCfg <= regWriteData[7:6];
      end
      if (regWrite && isHit(regAddr, ADDR_PIE)) begin
        pieBits <= regWriteData;
      end
      if (regWrite && isHit(regAddr, ADDR_PORTC_DIR)) begin
        portcDirection <= regWriteData[5:0];
      end
      if (regWrite && isHit(regAddr, ADDR_PORTA_DIR)) begin
        portaDirection <= regWriteData[5:0];
      end
      if (regWrite && isHit(regAddr, ADDR_PIR)) begin
        pirFlags <= regWriteData;
      end
      if (byteDone) begin
        pirFlags[PIR_SERIAL] <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      unique case (regAddr)
        ADDR_PIR: regReadData <= pirFlags;
        ADDR_BUF: regReadData <= serialBuffer;
        ADDR_CON: regReadData <= serialControl;
        ADDR_PIE: regReadData <= pieBits;
        ADDR_STAT: regReadData <= {statusCfg, 5'h00, bufferFull};
        ADDR_PORTA_DIR: regReadData <= {2'h0, portaDirection};
        ADDR_PORTC_DIR: regReadData <= {2'h0, portcDirection};
        default: regReadData <= 8'h00;
      endcase
    end else begin
      regReadData <= 8'h00;
    end
  end

  // pins: a pin programmed against its serial role is left to general i/o
  assign sckOut = (masterMode && state != ST_IDLE) ? ((state == ST_TRAIL) ^ serialControl[CON_POLARITY]) :
    serialControl[CON_POLARITY];
  assign sckOe = masterMode && !portcDirection[DIR_SCK];
  assign sdoOe = portOn && !portcDirection[DIR_SDO] && !slaveHold;
  assign wakeRequest = sleepMode && slaveMode && pirFlags[PIR_SERIAL] && pieBits[PIR_SERIAL];

  a_read_clears_full: assert property (@(posedge clk_sys) disable iff (reset)
    bufRead && !byteDone |=> !bufferFull) else $error("full flag not cleared");
  a_done_sets_flags: assert property (@(posedge clk_sys) disable iff (reset)
    byteDone |=> bufferFull && pirFlags[PIR_SERIAL]) else $error("flags not set");
  a_collision_flag: assert property (@(posedge clk_sys) disable iff (reset)
    bufWrite && busy |=> serialControl[CON_COLLISION]) else $error("no collision");
  a_collision_keeps_buf: assert property (@(posedge clk_sys) disable iff (reset)
    bufWrite && busy && !byteDone |=> $stable(serialBuffer)) else $error("buffer changed");
  a_no_master_ovf: assert property (@(posedge clk_sys) disable iff (reset)
    masterMode && !serialControl[CON_OVERFLOW] && !(regWrite && regAddr == ADDR_CON)
    |=> !serialControl[CON_OVERFLOW]) else $error("overflow in master");
  a_ss_floats_sdo: assert property (@(posedge clk_sys) disable iff (reset)
    slaveHold |-> !sdoOe) else $error("sdo driven with ss high");
  a_ss_resets: assert property (@(posedge clk_sys) disable iff (reset)
    slaveHold |=> state == ST_IDLE) else $error("engine not reset");
  a_master_starts: assert property (@(posedge clk_sys) disable iff (reset)
    masterMode && bufWrite && !busy |=> state == ST_LEAD) else $error("no start");
  a_disabled_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !portOn |=> !busy) else $error("busy while disabled");
  a_sck_idle: assert property (@(posedge clk_sys) disable iff (reset)
    !busy |-> sckOut == serialControl[CON_POLARITY]) else $error("sck idle level");
  c_master_byte: cover property (@(posedge clk_sys) masterMode && byteDone);
  c_slave_byte: cover property (@(posedge clk_sys) slaveMode && byteDone);
  c_overflow: cover property (@(posedge clk_sys) byteDone && slaveMode && bufferFull);
  c_collision: cover property (@(posedge clk_sys) bufWrite && busy);
endmodule
`default_nettype wire

//--- tb/ssppe_partner.sv
// Purpose: far-side spi party for the serial port engine bench
// Assumes: one clock; sck edges are seen on clk_sys
// Notes: a released sdi toggles every cycle so stale data never passes
`timescale 1ns/100ps
`default_nettype none
module ssppe_partner (
  input wire logic clk_sys,
  input wire logic cpol,
  input wire logic slvOn,
  input wire logic sckLine,
  input wire logic sdoLine,
  output logic sdiOut,
  output logic sckDrv,
  output logic [7:0] rxSh
);
  logic [7:0] txSh = 8'h00;
  logic sckQ = 1'b0;
  logic busy = 1'b0;
  initial sdiOut = 1'b0;
  initial sckDrv = 1'b0;
  initial rxSh = 8'h00;
  always @(posedge clk_sys) begin
    sckQ <= sckLine;
    if (!busy) begin
      // clock stands at its idle level outside frames
      sckDrv <= cpol;
      if (!slvOn)
        sdiOut <= ~sdiOut;
      else if (sckLine != cpol && sckQ == cpol)
        rxSh <= {rxSh[6:0], sdoLine};
      else if (sckLine == cpol && sckQ != cpol) begin
        txSh <= {txSh[6:0], 1'b0};
        sdiOut <= txSh[6];
      end
    end
  end
  task load(input logic [7:0] b);
    txSh <= b;
    sdiOut <= b[7];
  endtask
  // acting as master: nBits msb first, hp cycles each half bit
  task xfer(input logic [7:0] tx, input int hp, input int nBits);
    busy = 1'b1;
    // one edge passes first so the idle branch never drives in the same step
    @(posedge clk_sys);
    for (int i = 7; i >= 8 - nBits; i--) begin
      sdiOut <= tx[i];
      repeat (hp) @(posedge clk_sys);
      sckDrv <= ~cpol;
      repeat (hp - 1) @(posedge clk_sys);
      rxSh <= {rxSh[6:0], sdoLine};
      @(posedge clk_sys);
      sckDrv <= cpol;
    end
    repeat (hp) @(posedge clk_sys);
    busy = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- tb/test_spi_serial_port_engine.sv
// Purpose: self-checking bench for the spi serial port engine
// Assumes: 25 MHz clk_sys; partner model on the serial pins
// Notes: slave bit rate kept slow so the pin synchronisers keep up
`timescale 1ns/100ps
`default_nettype none
module test_spi_serial_port_engine
  import ssppe_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic timerTwoOutput = 1'b0;
  logic sleepMode = 1'b0;
  logic ssIn = 1'b1;
  logic cpol = 1'b0;
  logic slvOn = 1'b1;
  logic lastSdo = 1'b0;
  logic [7:0] regReadData, rxP, rdv, b, r;
  logic wakeRequest, sckOut, sckOe, sdoOut, sdoOe, sdiP, sckDrv, sckLine, sdoLine;
  int mismatches = 0;
  int n_compared = 0;
  int actCnt = 0;
  int oeCnt = 0;
  int base = 0;
  int cyc = 0;
  // an undriven sdo shows the inverse of its last value, never a stale copy
  assign sckLine = (sckOe === 1'b1) ? sckOut : sckDrv;
  assign sdoLine = (sdoOe === 1'b1) ? sdoOut : ~lastSdo;
  ssppe_engine u_dut (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .timerTwoOutput(timerTwoOutput),
    .sleepMode(sleepMode), .wakeRequest(wakeRequest), .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
    .sdiIn(sdiP), .sdoOut(sdoOut), .sdoOe(sdoOe), .ssIn(ssIn));
  ssppe_partner u_partner (.clk_sys(clk_sys), .cpol(cpol), .slvOn(slvOn), .sckLine(sckLine),
    .sdoLine(sdoLine), .sdiOut(sdiP), .sckDrv(sckDrv), .rxSh(rxP));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3)
      timerTwoOutput <= ~timerTwoOutput;
    if (sckOe === 1'b1 && sckOut !== cpol)
      actCnt <= actCnt + 1;
    if (sckOe === 1'b1 || sdoOe === 1'b1)
      oeCnt <= oeCnt + 1;
    if (sdoOe === 1'b1)
      lastSdo <= sdoOut;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  function int expAct(input int m);
    return (m == 3) ? 64 : (16 << (2 * m));
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
    @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regReadData;
    @(posedge clk_sys);
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rdv);
    chk(rdv, exp);
  endtask
  task waitFull;
    rdv = 8'h00;
    for (int k = 0; k < 300 && rdv[0] !== 1'b1; k++)
      rd(ADDR_STAT, rdv);
  endtask
  task complete_run;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hfadd57b6));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rchk(ADDR_CON, RESET_CON);
    rchk(ADDR_STAT, RESET_STAT);
    rchk(ADDR_PIR, RESET_PIR);
    rchk(ADDR_PIE, RESET_PIE);
    rchk(ADDR_PORTC_DIR, {2'h0, RESET_DIR});
    rchk(8'h55, 8'h00);
    $display("test reset values done");
    wr(ADDR_PORTC_DIR, 8'h17);
    for (int m = 0; m < 4; m++) begin
      cpol <= (m == 1);
      wr(ADDR_CON, 8'h00);
      wr(ADDR_CON, 8'h20 | ((m == 1) ? 8'h10 : 8'h00) | 8'(m));
      b = 8'($urandom);
      r = 8'($urandom);
      u_partner.load(r);
      base = actCnt;
      wr(ADDR_BUF, b);
      waitFull();
      chk(rdv[0], 1);
      chk(actCnt - base, expAct(m));
      chk(sckOut, cpol);
      chk(rxP, b);
      // the fastest rate leaves sdi too little time through the synchroniser
      if (m != 0)
        rchk(ADDR_BUF, r);
      else
        rd(ADDR_BUF, rdv);
      rchk(ADDR_STAT, 8'h00);
      rchk(ADDR_PIR, 8'h08);
      wr(ADDR_PIR, 8'h00);
      $display("test master mode %0d done", m);
    end
    wr(ADDR_CON, 8'h00);
    wr(ADDR_CON, 8'h21);
    b = 8'($urandom);
    wr(ADDR_BUF, b);
    wr(ADDR_BUF, ~b);
    waitFull();
    chk(rxP, b);
    rchk(ADDR_CON, 8'ha1);
    wr(ADDR_CON, 8'h21);
    rchk(ADDR_CON, 8'h21);
    rd(ADDR_BUF, rdv);
    $display("test collision done");
    wr(ADDR_PORTC_DIR, 8'h3f);
    base = oeCnt;
    wr(ADDR_BUF, 8'($urandom));
    waitFull();
    chk(rdv[0], 1);
    chk(oeCnt - base, 0);
    rd(ADDR_BUF, rdv);
    wr(ADDR_CON, 8'h01);
    wr(ADDR_PORTC_DIR, 8'h17);
    wr(ADDR_BUF, 8'h3c);
    repeat (100) @(posedge clk_sys);
    rchk(ADDR_STAT, 8'h00);
    $display("test pin override and disable done");
    slvOn <= 1'b0;
    cpol <= 1'b0;
    wr(ADDR_PIR, 8'h00);
    wr(ADDR_PORTC_DIR, 8'h1f);
    wr(ADDR_CON, 8'h25);
    wr(ADDR_PIE, 8'h08);
    sleepMode <= 1'b1;
    b = 8'($urandom);
    r = 8'($urandom);
    wr(ADDR_BUF, b);
    u_partner.xfer(r, 8, 8);
    chk(rxP, b);
    chk(wakeRequest, 1);
    rchk(ADDR_BUF, r);
    wr(ADDR_PIR, 8'h00);
    chk(wakeRequest, 0);
    u_partner.xfer(8'h5a, 8, 8);
    u_partner.xfer(8'ha5, 8, 8);
    rchk(ADDR_CON, 8'h65);
    rchk(ADDR_BUF, 8'h5a);
    sleepMode <= 1'b0;
    $display("test slave free select done");
    wr(ADDR_CON, 8'h00);
    wr(ADDR_CON, 8'h24);
    repeat (4) @(posedge clk_sys);
    chk(sdoOe, 0);
    ssIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk(sdoOe, 1);
    wr(ADDR_BUF, 8'($urandom));
    u_partner.xfer(8'hff, 8, 3);
    ssIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(sdoOe, 0);
    rchk(ADDR_STAT, 8'h00);
    ssIn <= 1'b0;
    repeat (4) @(posedge clk_sys);
    b = 8'($urandom);
    r = 8'($urandom);
    wr(ADDR_BUF, b);
    u_partner.xfer(r, 8, 8);
    chk(rxP, b);
    rchk(ADDR_BUF, r);
    wr(ADDR_PORTA_DIR, 8'h1f);
    ssIn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk(sdoOe, 1);
    $display("test slave select gating done");
    complete_run();
  end
endmodule
`default_nettype wire
